// ==== design/vmc_arm_detect.sv ====
/*
  Set-clear-set detector for one arming bit of the mode register.
  Assumes wrStrobe is a one-cycle pulse per register write and bitValue
  is the written value of the watched bit in that cycle.
*/
`timescale 1ns/1ps
module vmc_arm_detect #(
  parameter int WINDOW_CYCLES = vmc_pkg::ARM_WINDOW_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Write of the watched bit
  input  wire logic wrStrobe,
  input  wire logic bitValue,
  // One-cycle action pulse
  output logic      fire
);

  typedef enum logic [1:0] {ARM_IDLE, ARM_SET, ARM_CLEARED} vmc_arm_state_t;

  // Last count inside the window, cut to the counter width on purpose
  localparam int                              LAST_COUNT_I = WINDOW_CYCLES - 1;
  localparam logic [vmc_pkg::ARM_COUNT_W-1:0] LAST_COUNT   =
    LAST_COUNT_I[vmc_pkg::ARM_COUNT_W-1:0];

  vmc_arm_state_t                   state;
  logic [vmc_pkg::ARM_COUNT_W-1:0]  count;
  logic                             expired;

  assign expired = (count >= LAST_COUNT);

  // Window is timed from the first set write
  always_ff @(posedge clk)
  begin
    if (reset || state == ARM_IDLE)
      count <= '0;
    else if (!expired)
      count <= count + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state <= ARM_IDLE;
      fire  <= 1'b0;
    end
    else
    begin
      fire <= 1'b0;
      case (state)
        ARM_IDLE:
          if (wrStrobe && bitValue)
            state <= ARM_SET;
        ARM_SET:
          if (expired)
            state <= (wrStrobe && bitValue) ? ARM_SET : ARM_IDLE; // RULE_15
          else if (wrStrobe && !bitValue)
            state <= ARM_CLEARED;
        ARM_CLEARED:
          if (wrStrobe && bitValue && !expired)
          begin
            fire  <= 1'b1;
            state <= ARM_IDLE;
          end
          else if (expired)
            state <= ARM_IDLE; // RULE_15
        default:
          state <= ARM_IDLE;
      endcase
    end
  end

  window_abandon_a: assert property (@(posedge clk) disable iff (reset) // RULE_15
    (state == ARM_CLEARED && expired) |=> (!fire && state != ARM_CLEARED))
    else $error("arming sequence survived its window");

  fire_cause_a: assert property (@(posedge clk) disable iff (reset) // RULE_06
    fire |-> ($past(wrStrobe) && $past(bitValue) && $past(state) == ARM_CLEARED))
    else $error("arming pulse without a final set write");

endmodule

// ==== design/vmc_mode_register.sv ====
/*
  Vendor mode configuration register: a 16-bit command register holding
  the cascade role, alert response gate, ordering style, two armed
  actions, converter time, fault-input gate and averaging selection.
  Assumes the command interface decoder delivers one-cycle write and read
  strobes with the command code, and that password unlock and alert
  response address reads arrive as one-cycle pulses from their owners.
*/
// Function
// [RULE_01] Bits 15:14 pick role: 00 common/single device, 01 cascaded target.
// [RULE_02] Role 10 is cascaded controller latching off, 11 cascaded controller retrying.
// [RULE_03] Host keeps multi-device secondary group out of cascaded sequencing.
// [RULE_04] Bit 13 gates whether alert response address reads are answered.
// [RULE_05] Bit 12 picks time-based (0) or event-based timeslot (1) sequencing.
// [RULE_06] Bit 11 set, cleared, set within 8 ms causes a soft reset.
// [RULE_07] Bit 10 set, cleared, set within 8 ms enters password protection.
// [RULE_08] Lock arming bit clears itself whenever the password is unlocked; a same-cycle write setting the bit wins here.
// [RULE_09] Host does at most 256 lock/unlock cycles before reset or power cycle.
// [RULE_10] Bits 9:8 always read zero.
// [RULE_11] Bits 7:6 set conversion time 1, 2, 4 or 8 microseconds.
// [RULE_12] Host leaves the register alone while supplies are running.
// [RULE_13] Bit 4 clear: low fault input shuts global channels; set: ignored.
// [RULE_14] Bits 3:2 select averaging of none, 2, 4 or 8 samples.
// [RULE_15] Arming window runs from first set; expiry abandons the sequence.
`timescale 1ns/1ps
module vmc_mode_register #(
  parameter int ARM_WINDOW_CYCLES = vmc_pkg::ARM_WINDOW_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Command interface
  input  wire logic        cmdWrite,
  input  wire logic        cmdRead,
  input  wire logic [7:0]  cmdCode,
  input  wire logic [15:0] writeData,
  output logic [15:0]      readData,
  output logic             readValid,
  // Alert response address
  input  wire logic        araRequest,
  output logic             araAck,
  // Password and fault input
  input  wire logic        passwordUnlock,
  input  wire logic        faultInLow,
  // Mode outputs
  output vmc_pkg::vmc_mode_t mode,
  output vmc_pkg::vmc_role_t role,
  output logic             lockActive,
  output logic             softResetPulse,
  output logic             globalShutdown,
  output logic [9:0]       convCycles,
  output logic [3:0]       averageSamples
);

  logic               modeWrite;
  logic               lockFire;
  logic               lockSetWrite;
  vmc_pkg::vmc_mode_t next_mode;

  assign modeWrite    = cmdWrite && (cmdCode == vmc_pkg::CMD_VENDOR_MODE);
  assign lockSetWrite = modeWrite && writeData[vmc_pkg::LOCK_BIT];

  always_comb
  begin
    next_mode.cascadeRoleSelect   = writeData[vmc_pkg::ROLE_LSB +: 2];
    next_mode.alertEnable         = writeData[vmc_pkg::ALERT_BIT]; // RULE_04
    next_mode.orderingStyleSelect = writeData[vmc_pkg::ORDER_BIT]; // RULE_05
    next_mode.softResetArm        = writeData[vmc_pkg::SOFT_RESET_BIT];
    next_mode.lockArm             = writeData[vmc_pkg::LOCK_BIT];
    next_mode.convTimeCode        = writeData[vmc_pkg::CONV_TIME_LSB +: 2];
    next_mode.faultIgnore         = writeData[vmc_pkg::FAULT_IGN_BIT];
    next_mode.averageCode         = writeData[vmc_pkg::AVERAGE_LSB +: 2];
  end

  // Stored fields; a write setting the lock bit beats a same-cycle unlock
  always_ff @(posedge clk)
  begin
    if (reset)
      mode <= '0;
    else if (modeWrite)
      mode <= next_mode; // RULE_01
    else if (passwordUnlock)
      mode.lockArm <= 1'b0; // RULE_08
  end

  // Decoded role, kept in step with the stored field
  always_ff @(posedge clk)
  begin
    if (reset)
      role <= '{common: 1'b1, target: 1'b0, ctrlLatchoff: 1'b0, ctrlRetry: 1'b0};
    else if (modeWrite)
    begin
      role.common       <= (next_mode.cascadeRoleSelect == vmc_pkg::ROLE_COMMON); // RULE_01
      role.target       <= (next_mode.cascadeRoleSelect == vmc_pkg::ROLE_TARGET); // RULE_01
      role.ctrlLatchoff <= (next_mode.cascadeRoleSelect == vmc_pkg::ROLE_CTRL_LATCH); // RULE_02
      role.ctrlRetry    <= (next_mode.cascadeRoleSelect == vmc_pkg::ROLE_CTRL_RETRY); // RULE_02
    end
  end

  // Converter time and averaging, both scaled by a power of two of the code
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      convCycles     <= vmc_pkg::CONV_BASE_CYCLES;
      averageSamples <= 4'h1;
    end
    else if (modeWrite)
    begin
      convCycles     <= vmc_pkg::CONV_BASE_CYCLES << next_mode.convTimeCode; // RULE_11
      averageSamples <= 4'h1 << next_mode.averageCode; // RULE_14
    end
  end

  // Read-back; reserved bits forced to zero
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      readData  <= 16'h0000;
      readValid <= 1'b0;
    end
    else
    begin
      readValid <= cmdRead && (cmdCode == vmc_pkg::CMD_VENDOR_MODE);
      if (cmdRead && (cmdCode == vmc_pkg::CMD_VENDOR_MODE))
        readData <= {mode.cascadeRoleSelect, mode.alertEnable, mode.orderingStyleSelect,
                     mode.softResetArm, mode.lockArm, 2'h0, // RULE_10
                     mode.convTimeCode, 1'b0, mode.faultIgnore, mode.averageCode, 2'h0};
    end
  end

  // Alert response address reads answered only when enabled
  always_ff @(posedge clk)
  begin
    if (reset)
      araAck <= 1'b0;
    else
      araAck <= araRequest && mode.alertEnable; // RULE_04
  end

  // Shared fault input gate
  always_ff @(posedge clk)
  begin
    if (reset)
      globalShutdown <= 1'b0;
    else
      globalShutdown <= faultInLow && !mode.faultIgnore; // RULE_13
  end

  // Armed actions; the arming bits must see a written clear between sets
  vmc_arm_detect #(
    .WINDOW_CYCLES (ARM_WINDOW_CYCLES)
  ) softResetArmer (
    .clk      (clk),
    .reset    (reset),
    .wrStrobe (modeWrite),
    .bitValue (writeData[vmc_pkg::SOFT_RESET_BIT]),
    .fire     (softResetPulse)
  ); // RULE_06

  vmc_arm_detect #(
    .WINDOW_CYCLES (ARM_WINDOW_CYCLES)
  ) lockArmer (
    .clk      (clk),
    .reset    (reset),
    .wrStrobe (modeWrite),
    .bitValue (writeData[vmc_pkg::LOCK_BIT]),
    .fire     (lockFire)
  ); // RULE_07

  // Lock wins over a same-cycle unlock so no lock request is lost
  always_ff @(posedge clk)
  begin
    if (reset)
      lockActive <= 1'b0;
    else if (lockFire)
      lockActive <= 1'b1; // RULE_07
    else if (passwordUnlock)
      lockActive <= 1'b0; // RULE_08
  end

  role_write_a: assert property (@(posedge clk) disable iff (reset) // RULE_01
    modeWrite |=> (mode.cascadeRoleSelect == $past(writeData[15:14])
                   && role.target == ($past(writeData[15:14]) == 2'h1)
                   && role.common == ($past(writeData[15:14]) == 2'h0)))
    else $error("cascade role not taken from write");

  ctrl_role_a: assert property (@(posedge clk) disable iff (reset) // RULE_02
    (modeWrite && writeData[15]) |=> (role.ctrlRetry == $past(writeData[14])
                                      && role.ctrlLatchoff == !$past(writeData[14])))
    else $error("controller role decode wrong");

  ara_gate_a: assert property (@(posedge clk) disable iff (reset) // RULE_04
    araRequest |=> (araAck == $past(mode.alertEnable)))
    else $error("alert response not gated by enable");

  ordering_style_a: assert property (@(posedge clk) disable iff (reset) // RULE_05
    modeWrite |=> (mode.orderingStyleSelect == $past(writeData[12])))
    else $error("ordering style not written");

  soft_reset_a: assert property (@(posedge clk) disable iff (reset) // RULE_06
    softResetPulse |-> ($past(modeWrite) && $past(writeData[11])) ##1 !softResetPulse)
    else $error("soft reset without final set write or too long");

  lock_enter_a: assert property (@(posedge clk) disable iff (reset) // RULE_07
    $rose(lockActive) |-> ($past(modeWrite, 2) && $past(writeData[10], 2)))
    else $error("lock entered without final set write");

  unlock_clear_a: assert property (@(posedge clk) disable iff (reset) // RULE_08
    (passwordUnlock && !lockSetWrite && !lockFire) |=> (!mode.lockArm && !lockActive))
    else $error("unlock did not clear lock");

  reserved_zero_a: assert property (@(posedge clk) disable iff (reset) // RULE_10
    (cmdRead && cmdCode == vmc_pkg::CMD_VENDOR_MODE) |=> (readValid && readData[9:8] == 2'h0
                                                          && readData[5] == 1'b0
                                                          && readData[1:0] == 2'h0))
    else $error("read not answered or reserved bits nonzero");

  conv_time_a: assert property (@(posedge clk) disable iff (reset) // RULE_11
    modeWrite |=> (convCycles == (10'd50 << $past(writeData[7:6]))))
    else $error("conversion time count wrong");

  fault_gate_a: assert property (@(posedge clk) disable iff (reset) // RULE_13
    faultInLow |=> (globalShutdown == !$past(mode.faultIgnore)))
    else $error("fault input gating wrong");

  average_count_a: assert property (@(posedge clk) disable iff (reset) // RULE_14
    modeWrite |=> (averageSamples == (4'h1 << $past(writeData[3:2]))))
    else $error("averaging count wrong");

endmodule

// ==== design/vmc_pkg.sv ====
/*
  Shared constants and carrier types for the vendor mode configuration
  register. Assumes a 50 MHz core clock and one synchronous reset.
*/
package vmc_pkg;

  // Command code of the mode register on the command interface
  localparam logic [7:0]  CMD_VENDOR_MODE   = 8'hd1;
  localparam logic [15:0] MODE_RESET_VALUE  = 16'h0000;

  // Field positions
  localparam int ROLE_LSB        = 14;
  localparam int ALERT_BIT       = 13;
  localparam int ORDER_BIT       = 12;
  localparam int SOFT_RESET_BIT  = 11;
  localparam int LOCK_BIT        = 10;
  localparam int CONV_TIME_LSB   = 6;
  localparam int FAULT_IGN_BIT   = 4;
  localparam int AVERAGE_LSB     = 2;

  // Cascade role codes
  localparam logic [1:0] ROLE_COMMON       = 2'h0;
  localparam logic [1:0] ROLE_TARGET       = 2'h1;
  localparam logic [1:0] ROLE_CTRL_LATCH   = 2'h2;
  localparam logic [1:0] ROLE_CTRL_RETRY   = 2'h3;

  // Timing
  localparam int CLK_PERIOD_NS     = 20;
  localparam int ARM_WINDOW_MS     = 8;
  // Longest time: rounds down
  localparam int ARM_WINDOW_CYCLES = (ARM_WINDOW_MS * 1000000) / CLK_PERIOD_NS;
  localparam int CONV_BASE_US      = 1;
  localparam int CONV_BASE_CYCLES_I = (CONV_BASE_US * 1000) / CLK_PERIOD_NS;
  localparam logic [9:0] CONV_BASE_CYCLES = 10'(CONV_BASE_CYCLES_I);
  localparam int ARM_COUNT_W       = 20;

  // Stored mode fields
  typedef struct packed {
    logic [1:0] cascadeRoleSelect;
    logic       alertEnable;
    logic       orderingStyleSelect;
    logic       softResetArm;
    logic       lockArm;
    logic [1:0] convTimeCode;
    logic       faultIgnore;
    logic [1:0] averageCode;
  } vmc_mode_t;

  // Decoded cascade role
  typedef struct packed {
    logic common;
    logic target;
    logic ctrlLatchoff;
    logic ctrlRetry;
  } vmc_role_t;

endpackage

// ==== tb/tb_vendor_mode_config_register.sv ====
/*
  Self-checking bench for the vendor mode configuration register.
  Assumes the host model owns the command strobes; arming window shortened.
*/
`timescale 1ns/1ps
module tb_vendor_mode_config_register;
  localparam int WIN = 40;
  logic               clk, reset, cmdWrite, cmdRead, readValid, araRequest, araAck;
  logic               passwordUnlock, faultInLow, lockActive, softResetPulse, globalShutdown;
  logic [7:0]         cmdCode;
  logic [15:0]        writeData, readData, rd;
  logic [9:0]         convCycles;
  logic [3:0]         averageSamples;
  logic               ok;
  vmc_pkg::vmc_mode_t mode;
  vmc_pkg::vmc_role_t role;
  int                 fails = 0;
  int                 check_count = 0;
  int                 srCount = 0;
  int                 n0;

  vmc_mode_register #(.ARM_WINDOW_CYCLES(WIN)) dut (.clk(clk), .reset(reset),
    .cmdWrite(cmdWrite), .cmdRead(cmdRead), .cmdCode(cmdCode), .writeData(writeData),
    .readData(readData), .readValid(readValid), .araRequest(araRequest), .araAck(araAck),
    .passwordUnlock(passwordUnlock), .faultInLow(faultInLow), .mode(mode), .role(role),
    .lockActive(lockActive), .softResetPulse(softResetPulse),
    .globalShutdown(globalShutdown), .convCycles(convCycles),
    .averageSamples(averageSamples));
  vmc_host_model host (.clk(clk), .cmdWrite(cmdWrite), .cmdRead(cmdRead),
    .cmdCode(cmdCode), .writeData(writeData), .readData(readData), .readValid(readValid));

  always #10 clk = ~clk;
  // Pulse is one cycle wide, so count it rather than sample it
  always @(posedge clk) if (softResetPulse === 1'b1) srCount <= srCount + 1;

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] d);
    host.writeReg(vmc_pkg::CMD_VENDOR_MODE, d);
  endtask

  task automatic readCheck(input string name, input logic [15:0] exp);
    host.readReg(rd, ok);
    check({name, " valid"}, 16'(ok), 16'h0001);
    check(name, rd, exp);
  endtask

  task automatic pulseIn(input logic ara, input logic unlock);
    @(posedge clk);
    #1;
    araRequest     = ara;
    passwordUnlock = unlock;
    @(posedge clk);
    #1;
    araRequest     = 1'b0;
    passwordUnlock = 1'b0;
  endtask

  task automatic test_reset();
    check("mode", 16'(mode), 16'h0000);
    check("role", 16'(role), 16'h0008);
    check("conv", 16'(convCycles), 16'h0032);
    check("avg", 16'(averageSamples), 16'h0001);
    readCheck("read reset", vmc_pkg::MODE_RESET_VALUE);
    $display("test_reset done");
  endtask

  // Reset in mid-run must drop every stored field back to idle
  task automatic test_mid_reset();
    wr(16'hc0cc);
    @(posedge clk);
    #1;
    reset = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    reset = 1'b0;
    check("mode after reset", 16'(mode), 16'h0000);
    check("role after reset", 16'(role), 16'h0008);
    check("conv after reset", 16'(convCycles), 16'h0032);
    check("avg after reset", 16'(averageSamples), 16'h0001);
    readCheck("read after reset", 16'h0000);
    $display("test_mid_reset done");
  endtask

  task automatic test_roles();
    for (int k = 0; k < 4; k++)
    begin
      wr({2'(k), 14'h0000});
      check("role", 16'(role), 16'(4'h8 >> k));
      check("role field", 16'(mode.cascadeRoleSelect), 16'(k));
      readCheck("read role", {2'(k), 14'h0000});
    end
    $display("test_roles done");
  endtask

  task automatic test_fields();
    for (int k = 0; k < 4; k++)
    begin
      wr({6'h00, 2'h3, 2'(k), 2'h3, 2'(k), 2'h3});
      check("conv", 16'(convCycles), 16'(50 << k));
      check("avg", 16'(averageSamples), 16'(1 << k));
      readCheck("read masked", {8'h00, 2'(k), 2'h1, 2'(k), 2'h0});
    end
    $display("test_fields done");
  endtask

  task automatic test_alert_fault();
    wr(16'h0000);
    faultInLow = 1'b1;
    pulseIn(1'b1, 1'b0);
    check("ara off", 16'(araAck), 16'h0000);
    check("shutdown", 16'(globalShutdown), 16'h0001);
    wr(16'h3010);
    check("order", 16'(mode.orderingStyleSelect), 16'h0001);
    pulseIn(1'b1, 1'b0);
    check("ara on", 16'(araAck), 16'h0001);
    check("ignored", 16'(globalShutdown), 16'h0000);
    faultInLow = 1'b0;
    wr(16'h0000);
    check("order", 16'(mode.orderingStyleSelect), 16'h0000);
    $display("test_alert_fault done");
  endtask

  task automatic test_soft_reset();
    n0 = srCount;
    wr(16'h0800);
    // Foreign code is refused and must not count as the clear
    host.writeReg(8'hd2, 16'h0000);
    wr(16'h0800);
    repeat (2) @(posedge clk);
    check("no early reset", 16'(srCount - n0), 16'h0000);
    wr(16'h0000);
    wr(16'h0800);
    repeat (2) @(posedge clk);
    check("soft reset", 16'(srCount - n0), 16'h0001);
    n0 = srCount;
    wr(16'h0000);
    wr(16'h0800);
    wr(16'h0000);
    repeat (WIN + 10) @(posedge clk);
    wr(16'h0800);
    repeat (2) @(posedge clk);
    check("expired", 16'(srCount - n0), 16'h0000);
    $display("test_soft_reset done");
  endtask

  task automatic test_lock();
    wr(16'h0400);
    wr(16'h0000);
    wr(16'h0400);
    repeat (3) @(posedge clk);
    #1;
    check("locked", 16'(lockActive), 16'h0001);
    pulseIn(1'b0, 1'b1);
    check("unlocked", 16'(lockActive), 16'h0000);
    check("lock arm", 16'(mode.lockArm), 16'h0000);
    readCheck("read unlock", 16'h0000);
    $display("test_lock done");
  endtask

  task automatic finish_test();
    $display("Checks made %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    clk            = 1'b0;
    reset          = 1'b1;
    araRequest     = 1'b0;
    passwordUnlock = 1'b0;
    faultInLow     = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    reset = 1'b0;
    test_reset();
    test_roles();
    test_fields();
    test_alert_fault();
    test_soft_reset();
    test_lock();
    test_mid_reset();
    finish_test();
  end

  // Whole run is under two hundred cycles; this leaves wide margin
  initial
  begin
    #200us;
    fails++;
    $display("Watchdog expired");
    finish_test();
  end
endmodule

// ==== tb/vmc_host_model.sv ====
/*
  Host controller model driving the mode register command interface.
  Assumes one caller at a time and the 50 MHz core clock.
*/
`timescale 1ns/1ps
module vmc_host_model (
  // Clock
  input  wire logic        clk,
  // Command interface
  output logic             cmdWrite,
  output logic             cmdRead,
  output logic [7:0]       cmdCode,
  output logic [15:0]      writeData,
  input  wire logic [15:0] readData,
  input  wire logic        readValid
);
  initial
  begin
    cmdWrite  = 1'b0;
    cmdRead   = 1'b0;
    cmdCode   = 8'h00;
    writeData = 16'h0000;
  end

  // Bench only writes with supplies idle, few locks, single-device groups
  task automatic writeReg(input logic [7:0] code, input logic [15:0] data);
    @(posedge clk);
    #1;
    cmdWrite  = 1'b1;
    cmdCode   = code;
    writeData = data;
    @(posedge clk);
    #1;
    cmdWrite  = 1'b0;
    // Released lines must not echo the last word
    cmdCode   = ~code;
    writeData = ~data;
  endtask

  task automatic readReg(output logic [15:0] data, output logic ok);
    int i;
    @(posedge clk);
    #1;
    cmdRead = 1'b1;
    cmdCode = vmc_pkg::CMD_VENDOR_MODE;
    @(posedge clk);
    #1;
    cmdRead = 1'b0;
    cmdCode = ~vmc_pkg::CMD_VENDOR_MODE;
    ok      = 1'b0;
    data    = 16'h0000;
    for (i = 0; i < 4 && ok !== 1'b1; i++)
    begin
      if (readValid === 1'b1)
      begin
        ok   = 1'b1;
        data = readData;
      end
      else
      begin
        @(posedge clk);
        #1;
      end
    end
  endtask
endmodule
